//--- rtl/aios_defs.svh
// Register offsets, field positions, channel counts, code constants and clock rate for analog io scaling
`ifndef AIOS_DEFS_SVH
`define AIOS_DEFS_SVH
`define AIOS_CLK_HZ         10000000
`define AIOS_REG_CTRL       8'h00
`define AIOS_REG_STATUS     8'h04
`define AIOS_REG_MASK       8'h08
`define AIOS_REG_OUT_CFG    8'h0c
`define AIOS_REG_OUT_MIN    8'h10
`define AIOS_REG_OUT_MAX    8'h14
`define AIOS_REG_OUT_CODE   8'h18
`define AIOS_REG_IN_CFG     8'h1c
`define AIOS_REG_IN_VAL     8'h20
`define AIOS_REG_THR_CFG    8'h24
`define AIOS_REG_THR_LVL    8'h28
`define AIOS_REG_THR_DLY    8'h2c
`define AIOS_REG_THR_STATE  8'h30
`define AIOS_REG_SRC_BASE   8'h40
`define AIOS_N_SRC          4
`define AIOS_N_IN           2
`define AIOS_N_THR          4
`define AIOS_CODE_FULL      16'hffff
`define AIOS_CODE_4MA       16'h3333
`define AIOS_PCT_ONE        16'h8000
`define AIOS_WIRE_BREAK     16'h2000
`define AIOS_ST_WIRE        0
`define AIOS_ST_ALARM       2
`define AIOS_ST_TRIP        6
`define AIOS_ST_W           10
`endif

//--- rtl/aios_pkg.sv
// Types shared by the analog io scaling block
package aios_pkg;
   typedef enum logic [1:0] {
      AIOS_RANGE_0_20MA = 2'h0,
      AIOS_RANGE_4_20MA = 2'h1,
      AIOS_RANGE_0_10V  = 2'h2
   } aios_range_t;
   typedef enum logic [1:0] {
      AIOS_ST_IDLE   = 2'h0,
      AIOS_ST_TIMING = 2'h1,
      AIOS_ST_TRIPPED = 2'h3
   } aios_thr_state_t;
endpackage : aios_pkg

//--- rtl/aios_thr_if.sv
// Carrier between the block and one threshold element
`timescale 1ns/10ps
interface aios_thr_if;
   logic signed [15:0] value;
   logic signed [15:0] level;
   logic [15:0]        delay;
   logic               over;
   logic               alarm_en;
   logic               trip_en;
   logic               inhibit;
   logic               alarm;
   logic               trip;
   modport owner (output value, level, delay, over, alarm_en, trip_en, inhibit, input alarm, trip);
   modport elem  (input value, level, delay, over, alarm_en, trip_en, inhibit, output alarm, trip);
endinterface : aios_thr_if

//--- rtl/aios_thr_elem.sv
// One analog threshold element with pickup, delay timer and inhibit
`timescale 1ns/10ps
`include "aios_defs.svh"
module aios_thr_elem (
   input  wire logic  i_clk,
   input  wire logic  i_rst,
   aios_thr_if.elem   thr
);
   aios_pkg::aios_thr_state_t state_r;
   logic [15:0]               cnt_r;
   logic                      pickup;

   always_comb begin
      if (thr.over) begin
         pickup = thr.value > thr.level; // R12
      end else begin
         pickup = thr.value < thr.level; // R12
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_r <= aios_pkg::AIOS_ST_IDLE;
         cnt_r   <= 16'h0000;
      end else if (!pickup || thr.inhibit || !thr.trip_en) begin
         state_r <= aios_pkg::AIOS_ST_IDLE; // R15
         cnt_r   <= 16'h0000;
      end else begin
         unique case (state_r)
            aios_pkg::AIOS_ST_IDLE: begin
               state_r <= aios_pkg::AIOS_ST_TIMING;
               cnt_r   <= 16'h0001;
            end
            aios_pkg::AIOS_ST_TIMING: begin
               if (cnt_r >= thr.delay) begin
                  state_r <= aios_pkg::AIOS_ST_TRIPPED; // R11
               end else begin
                  cnt_r <= cnt_r + 16'h0001;
               end
            end
            aios_pkg::AIOS_ST_TRIPPED: begin
               state_r <= aios_pkg::AIOS_ST_TRIPPED;
            end
            default: begin
               state_r <= aios_pkg::AIOS_ST_IDLE;
            end
         endcase
      end
   end

   assign thr.alarm = pickup && thr.alarm_en && !thr.inhibit; // R10 R13
   // Trip drops with pickup, before the timer has been cleared
   assign thr.trip  = (state_r == aios_pkg::AIOS_ST_TRIPPED) && pickup && thr.trip_en && !thr.inhibit; // R10 R13

   a_trip_needs_pickup: assert property (@(posedge i_clk) disable iff (i_rst) // R15
      thr.trip |-> $past(pickup) && pickup) else $error("trip without held pickup");
   a_inhibit_blocks_out: assert property (@(posedge i_clk) disable iff (i_rst) // R13
      thr.inhibit |-> !thr.alarm && !thr.trip) else $error("output while inhibited");
endmodule : aios_thr_elem

//--- rtl/aios_top.sv
// Analog output scaling, input ranging and threshold supervision with Wishbone registers
// Functional notes
// (R1) Each output channel offers 0-20 mA, 4-20 mA or 0-10 V range.
// (R2) Output follows exactly one selected source quantity, updated continuously.
// (R3) Source at lower bound gives 0 percent, at upper bound 100 percent.
// (R4) Percent is 100 over (max minus min) times (value minus min).
// (R5) 4-20 mA current is 4 mA plus percent times 16 mA.
// (R6) Power factor sign positive when active and reactive power share sign.
// (R7) Signed power factor bounds and input remapped as sign minus value.
// (R8) Each analog input gives one measuring value with selectable range.
// (R9) Each threshold element picks one measuring value; values may feed many.
// (R10) Alarm and trip stages are enabled separately and act only when active.
// (R11) Each element has a threshold and a trip delay after pickup.
// (R12) Over mode picks up above threshold, under mode below.
// (R13) 4-20 mA broken wire raises alarm and inhibits fed elements.
// (R14) Broken wire is a 4-20 mA reading well below 4 mA.
// (R15) Trip only after pickup persists full delay; dropout restarts timer.
//
// The Wishbone register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "aios_defs.svh"
module aios_top (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   input  wire logic [63:0] i_src_values,
   input  wire logic        i_p_neg,
   input  wire logic        i_q_neg,
   input  wire logic [31:0] i_adc_raw,
   output logic      [15:0] o_out_code,
   output logic             o_out_voltage,
   output logic      [3:0]  o_alarm,
   output logic      [3:0]  o_trip,
   output logic      [1:0]  o_wire_broken,
   output logic             o_irq
);
   logic [31:0]               ctrl_r;
   logic [`AIOS_ST_W-1:0]     status_r;
   logic [`AIOS_ST_W-1:0]     mask_r;
   logic [31:0]               out_cfg_r;
   logic signed [15:0]        out_min_r;
   logic signed [15:0]        out_max_r;
   logic [3:0]                in_cfg_r;
   logic [31:0]               thr_cfg_r;
   logic [63:0]               thr_lvl_r;
   logic [63:0]               thr_dly_r;
   logic signed [15:0]        in_val [`AIOS_N_IN];
   logic [1:0]                wire_bad;
   logic [3:0]                alarm;
   logic [3:0]                trip;
   logic [3:0]                alarm_d_r;
   logic [3:0]                trip_d_r;
   logic [1:0]                wire_d_r;
   logic [`AIOS_ST_W-1:0]     ev;
   logic                      wr;
   logic                      rd;
   logic signed [15:0]        src;
   logic signed [15:0]        pf_min;
   logic signed [15:0]        pf_max;
   logic signed [15:0]        pf_val;
   logic [15:0]               pct;
   logic [15:0]               code_nxt;
   logic [31:0]               rd_nxt;

   // Power factor remap: sign minus value, Q1.14 with one = 0x4000
   function automatic logic signed [15:0] pf_remap(input logic signed [15:0] v);
      pf_remap = v[15] ? -16'sh4000 - v : 16'sh4000 - v; // R7
   endfunction : pf_remap

   // Percentage in Q1.15 (0x8000 = 100 percent), clamped
   function automatic logic [15:0] lin_pct(input logic signed [15:0] v, input logic signed [15:0] lo,
                                            input logic signed [15:0] hi);
      logic signed [17:0] num;
      logic signed [17:0] den;
      logic signed [33:0] q;
      num = 18'(v) - 18'(lo);
      den = 18'(hi) - 18'(lo);
      if (den <= 0 || num <= 0) begin
         lin_pct = 16'h0000; // R3
      end else if (num >= den) begin
         lin_pct = `AIOS_PCT_ONE; // R3
      end else begin
         q       = (34'(num) <<< 15) / 34'(den); // R4
         lin_pct = q[15:0];
      end
   endfunction : lin_pct

   // Scale percentage onto a DAC code span
   function automatic logic [15:0] span(input logic [15:0] p, input logic [15:0] base);
      logic [31:0] prod;
      prod = 32'(p) * 32'(`AIOS_CODE_FULL - base);
      span = base + prod[30:15];
   endfunction : span

   assign wr = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack;
   assign rd = i_wb_cyc && i_wb_stb && !o_wb_ack;

   // Source selection and output scaling
   always_comb begin
      src    = i_src_values[{out_cfg_r[3:2], 4'h0} +: 16]; // R2
      pf_val = i_src_values[{out_cfg_r[3:2], 4'h0} +: 16];
      if (out_cfg_r[4]) begin
         pf_val = (i_p_neg == i_q_neg) ? (src[15] ? -src : src) : (src[15] ? src : -src); // R6
         pf_min = pf_remap(out_min_r);
         pf_max = pf_remap(out_max_r);
         pct    = lin_pct(pf_remap(pf_val), pf_min, pf_max); // R7
      end else begin
         pf_min = out_min_r;
         pf_max = out_max_r;
         pct    = lin_pct(src, out_min_r, out_max_r); // R4
      end
      unique case (out_cfg_r[1:0])
         2'h1:    code_nxt = span(pct, `AIOS_CODE_4MA); // R5
         default: code_nxt = span(pct, 16'h0000); // R1
      endcase
   end

   // Input measuring values and broken-wire check
   always_comb begin
      for (int i = 0; i < `AIOS_N_IN; i++) begin
         in_val[i]   = $signed({1'b0, i_adc_raw[16*i+1 +: 15]}); // R8
         wire_bad[i] = (in_cfg_r[2*i +: 2] == 2'h1) && (i_adc_raw[16*i +: 16] < `AIOS_WIRE_BREAK); // R14
      end
   end

   genvar g;
   generate
      for (g = 0; g < `AIOS_N_THR; g++) begin : gen_thr
         aios_thr_if thr_bus ();
         logic sel;
         assign sel                = thr_cfg_r[8*g+4]; // R9
         assign thr_bus.value      = in_val[sel];
         assign thr_bus.level      = thr_lvl_r[16*g +: 16];
         assign thr_bus.delay      = thr_dly_r[16*g +: 16];
         assign thr_bus.over       = thr_cfg_r[8*g+2];
         assign thr_bus.alarm_en   = thr_cfg_r[8*g]; // R10
         assign thr_bus.trip_en    = thr_cfg_r[8*g+1]; // R10
         assign thr_bus.inhibit    = wire_bad[sel]; // R13
         assign alarm[g]           = thr_bus.alarm;
         assign trip[g]            = thr_bus.trip;
         aios_thr_elem u_elem (
            .i_clk (i_clk),
            .i_rst (i_rst),
            .thr   (thr_bus.elem)
         );
      end
   endgenerate

   assign ev = {trip & ~trip_d_r, alarm & ~alarm_d_r, wire_bad & ~wire_d_r};

   // Analog output code and range flag
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_out_code    <= 16'h0000;
         o_out_voltage <= 1'b0;
      end else begin
         o_out_code    <= ctrl_r[0] ? code_nxt : 16'h0000; // R1
         o_out_voltage <= out_cfg_r[1:0] == 2'h2;
      end
   end

   // Supervision outputs
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_alarm       <= 4'h0;
         o_trip        <= 4'h0;
         o_wire_broken <= 2'h0;
      end else begin
         o_alarm       <= alarm;
         o_trip        <= trip;
         o_wire_broken <= wire_bad; // R13
      end
   end

   // Previous levels for status edge detection
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         alarm_d_r <= 4'h0;
         trip_d_r  <= 4'h0;
         wire_d_r  <= 2'h0;
      end else begin
         alarm_d_r <= alarm;
         trip_d_r  <= trip;
         wire_d_r  <= wire_bad;
      end
   end

   // Sticky status, write one to clear; set wins
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         status_r <= '0;
      end else if (wr && i_wb_adr == `AIOS_REG_STATUS && i_wb_sel[0]) begin
         status_r <= (status_r & ~i_wb_dat[`AIOS_ST_W-1:0]) | ev;
      end else begin
         status_r <= status_r | ev;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |((status_r | ev) & mask_r);
      end
   end

   // Configuration registers
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ctrl_r    <= 32'h0000_0000;
         mask_r    <= '0;
         out_cfg_r <= 32'h0000_0000;
         out_min_r <= 16'sh0000;
         out_max_r <= 16'sh7fff;
         in_cfg_r  <= 4'h0;
         thr_cfg_r <= 32'h0000_0000;
         thr_lvl_r <= 64'h0;
         thr_dly_r <= 64'h0;
      end else if (wr) begin
         unique case (i_wb_adr)
            `AIOS_REG_CTRL:    ctrl_r    <= i_wb_dat;
            `AIOS_REG_MASK:    mask_r    <= i_wb_dat[`AIOS_ST_W-1:0];
            `AIOS_REG_OUT_CFG: out_cfg_r <= i_wb_dat;
            `AIOS_REG_OUT_MIN: out_min_r <= i_wb_dat[15:0];
            `AIOS_REG_OUT_MAX: out_max_r <= i_wb_dat[15:0];
            `AIOS_REG_IN_CFG:  in_cfg_r  <= i_wb_dat[3:0]; // R8
            `AIOS_REG_THR_CFG: thr_cfg_r <= i_wb_dat;
            `AIOS_REG_THR_LVL: thr_lvl_r[16*i_wb_dat[17:16] +: 16] <= i_wb_dat[15:0]; // R11
            `AIOS_REG_THR_DLY: thr_dly_r[16*i_wb_dat[17:16] +: 16] <= i_wb_dat[15:0]; // R11
            default: ;
         endcase
      end
   end

   always_comb begin
      unique case (i_wb_adr)
         `AIOS_REG_CTRL:      rd_nxt = ctrl_r;
         `AIOS_REG_STATUS:    rd_nxt = 32'(status_r);
         `AIOS_REG_MASK:      rd_nxt = 32'(mask_r);
         `AIOS_REG_OUT_CFG:   rd_nxt = out_cfg_r;
         `AIOS_REG_OUT_MIN:   rd_nxt = {16'h0000, out_min_r};
         `AIOS_REG_OUT_MAX:   rd_nxt = {16'h0000, out_max_r};
         `AIOS_REG_OUT_CODE:  rd_nxt = {16'h0000, o_out_code};
         `AIOS_REG_IN_CFG:    rd_nxt = {28'h0, in_cfg_r};
         `AIOS_REG_IN_VAL:    rd_nxt = {in_val[1], in_val[0]};
         `AIOS_REG_THR_CFG:   rd_nxt = thr_cfg_r;
         `AIOS_REG_THR_STATE: rd_nxt = {22'h0, wire_bad, trip, alarm};
         default:             rd_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0000_0000;
      end else begin
         o_wb_ack <= rd;
         o_wb_dat <= rd ? rd_nxt : 32'h0000_0000;
      end
   end

   // Analog output checks
   a_four_ma_floor: assert property (@(posedge i_clk) disable iff (i_rst) // R5
      ctrl_r[0] && $past(ctrl_r[0]) && out_cfg_r[1:0] == 2'h1 && $past(out_cfg_r[1:0]) == 2'h1
      |-> o_out_code >= `AIOS_CODE_4MA) else $error("4-20 mA code below 4 mA");
   a_pct_lower_end: assert property (@(posedge i_clk) disable iff (i_rst) // R3
      !out_cfg_r[4] && src <= out_min_r |-> pct == 16'h0000) else $error("min not 0 percent");
   a_pct_upper_end: assert property (@(posedge i_clk) disable iff (i_rst) // R3
      !out_cfg_r[4] && src >= out_max_r && out_max_r > out_min_r |-> pct == `AIOS_PCT_ONE)
      else $error("max not 100 percent");
   a_pct_saturated: assert property (@(posedge i_clk) disable iff (i_rst) // R4
      pct <= `AIOS_PCT_ONE) else $error("percent above 100");
   a_zero_span_start: assert property (@(posedge i_clk) disable iff (i_rst) // R3
      ctrl_r[0] && out_cfg_r[1:0] == 2'h0 && pct == 16'h0000 |=> o_out_code == 16'h0000)
      else $error("0 percent not at span start");
   a_full_span_end: assert property (@(posedge i_clk) disable iff (i_rst) // R5
      ctrl_r[0] && pct == `AIOS_PCT_ONE |=> o_out_code == `AIOS_CODE_FULL)
      else $error("100 percent not at span end");
   a_code_disabled: assert property (@(posedge i_clk) disable iff (i_rst) // R1
      !ctrl_r[0] |=> o_out_code == 16'h0000) else $error("code while output disabled");
   a_voltage_range: assert property (@(posedge i_clk) disable iff (i_rst) // R1
      out_cfg_r[1:0] == 2'h2 |=> o_out_voltage) else $error("voltage range not shown");
   a_pf_sign_same: assert property (@(posedge i_clk) disable iff (i_rst) // R6
      out_cfg_r[4] && i_p_neg == i_q_neg && src != 16'sh8000 |-> !pf_val[15])
      else $error("power factor sign not positive");
   a_pf_sign_diff: assert property (@(posedge i_clk) disable iff (i_rst) // R6
      out_cfg_r[4] && i_p_neg != i_q_neg && src != 16'sh0000 |-> pf_val[15])
      else $error("power factor sign not negative");
   a_pf_lower_end: assert property (@(posedge i_clk) disable iff (i_rst) // R7
      out_cfg_r[4] && pf_val == out_min_r |-> pct == 16'h0000) else $error("power factor min not 0 percent");
   a_pf_upper_end: assert property (@(posedge i_clk) disable iff (i_rst) // R7
      out_cfg_r[4] && pf_val == out_max_r && pf_max > pf_min |-> pct == `AIOS_PCT_ONE)
      else $error("power factor max not 100 percent");

   // Supervision checks
   a_wire_only_4ma: assert property (@(posedge i_clk) disable iff (i_rst) // R14
      wire_bad[0] |-> in_cfg_r[1:0] == 2'h1) else $error("wire break outside 4-20 mA");
   a_wire_flag_out: assert property (@(posedge i_clk) disable iff (i_rst) // R13
      wire_bad[0] |=> o_wire_broken[0]) else $error("wire flag not shown");
   a_wire_blocks_out: assert property (@(posedge i_clk) disable iff (i_rst) // R13
      wire_bad[0] && !thr_cfg_r[4] |-> !alarm[0] && !trip[0]) else $error("element on broken wire active");

   // Status and interrupt checks
   a_status_set_wins: assert property (@(posedge i_clk) disable iff (i_rst)
      |ev |=> (status_r & $past(ev)) == $past(ev)) else $error("status event lost");
   a_irq_on_mask: assert property (@(posedge i_clk) disable iff (i_rst)
      |(status_r & mask_r) |=> o_irq) else $error("unmasked status without interrupt");
   a_irq_quiet_mask: assert property (@(posedge i_clk) disable iff (i_rst)
      !(|mask_r) |=> !o_irq) else $error("interrupt with all sources masked");

   // Bus handshake checks
   a_ack_one_cycle: assert property (@(posedge i_clk) disable iff (i_rst)
      o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
   a_ack_after_req: assert property (@(posedge i_clk) disable iff (i_rst)
      i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("request not acknowledged");
   a_dat_zero_idle: assert property (@(posedge i_clk) disable iff (i_rst)
      !o_wb_ack |-> o_wb_dat == 32'h0000_0000) else $error("read data without ack");
endmodule : aios_top

//--- verification/aios_transducer_model.sv
// Model of the external transducers feeding the two analog inputs
`timescale 1ns/10ps
module aios_transducer_model (
   input  wire logic [15:0] i_code0,
   input  wire logic [15:0] i_code1,
   input  wire logic        i_open0,
   output logic      [31:0] o_adc_raw
);
   // An open loop carries no current, so the converter reads zero
   assign o_adc_raw = {i_code1, i_open0 ? 16'h0000 : i_code0};
endmodule : aios_transducer_model

//--- verification/aios_top_test.sv
// Self-checking testbench for the analog io scaling block
`timescale 1ns/10ps
`include "aios_defs.svh"
module aios_top_test;
   logic        i_clk = 1'b0;
   logic        i_rst = 1'b1;
   logic        wb_cyc = 1'b0;
   logic        wb_stb = 1'b0;
   logic        wb_we = 1'b0;
   logic [7:0]  wb_adr = 8'h00;
   logic [3:0]  wb_sel = 4'h0;
   logic [31:0] wb_wdat = 32'h0;
   logic [63:0] src = 64'h0;
   logic        p_neg = 1'b0;
   logic        q_neg = 1'b0;
   logic [15:0] code0 = 16'h0;
   logic [15:0] code1 = 16'h0;
   logic        open0 = 1'b0;
   logic [31:0] wb_rdat, adc_raw, rd;
   logic        wb_ack, out_voltage, irq;
   logic [15:0] out_code, exp16;
   logic [3:0]  alarm, trip;
   logic [1:0]  wire_broken;
   int          n_errors = 0;
   int          compares = 0;
   int          cycles = 0;
   int          n;

   always #50 i_clk = ~i_clk;

   aios_transducer_model i_model (.i_code0(code0), .i_code1(code1), .i_open0(open0), .o_adc_raw(adc_raw));

   aios_top i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb), .i_wb_we(wb_we),
      .i_wb_adr(wb_adr), .i_wb_sel(wb_sel), .i_wb_dat(wb_wdat), .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack),
      .i_src_values(src), .i_p_neg(p_neg), .i_q_neg(q_neg), .i_adc_raw(adc_raw), .o_out_code(out_code),
      .o_out_voltage(out_voltage), .o_alarm(alarm), .o_trip(trip), .o_wire_broken(wire_broken), .o_irq(irq));

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      wb_cyc  <= 1'b1;
      wb_stb  <= 1'b1;
      wb_we   <= w;
      wb_adr  <= a;
      wb_wdat <= d;
      wb_sel  <= 4'hf;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 16);
      rd = wb_rdat;
      chk("wb_ack", 32'h1, {31'h0, wb_ack});
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we  <= 1'b0;
   endtask : wb

   task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask : rd_chk

   task settle;
      repeat (3) @(posedge i_clk);
   endtask : settle

   task pf_case(input logic p, input logic q, input logic [15:0] v, input logic [15:0] e);
      p_neg <= p;
      q_neg <= q;
      src[15:0] <= v;
      settle;
      chk("pf_code", {16'h0, e}, {16'h0, out_code});
   endtask : pf_case

   task results;
      $display("Comparisons %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : results

   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         results();
      end
   end

   initial begin
      repeat (12) @(posedge i_clk);
      i_rst <= 1'b0;
      rd_chk("status", `AIOS_REG_STATUS, 32'h0);
      wb(1'b1, 8'h3c, 32'hffffffff);
      rd_chk("unmapped", 8'h3c, 32'h0);
      $display("test reset done");
      wb(1'b1, `AIOS_REG_CTRL, 32'h1);
      wb(1'b1, `AIOS_REG_OUT_MIN, 32'h0100);
      wb(1'b1, `AIOS_REG_OUT_MAX, 32'h1100);
      src <= 64'h0000_0000_1100_0100;
      for (int r = 0; r < 3; r++) begin
         for (int s = 0; s < 2; s++) begin
            wb(1'b1, `AIOS_REG_OUT_CFG, 32'(r) | (32'(s) << 2));
            settle;
            exp16 = (s == 1) ? `AIOS_CODE_FULL : ((r == 1) ? `AIOS_CODE_4MA : 16'h0000);
            chk("out_code", {16'h0, exp16}, {16'h0, out_code});
            chk("out_voltage", {31'h0, r == 2}, {31'h0, out_voltage});
            rd_chk("out_code_reg", `AIOS_REG_OUT_CODE, {16'h0, exp16});
         end
      end
      wb(1'b1, `AIOS_REG_OUT_CFG, 32'h0);
      src[15:0] <= 16'h0900;
      settle;
      compares++;
      if ((out_code >= 16'h7ffe && out_code <= 16'h8001) !== 1'b1) begin
         n_errors++;
         $display("ERROR out_code_mid expected %h seen %h", 16'h8000, out_code);
      end
      $display("test output scaling done");
      wb(1'b1, `AIOS_REG_OUT_MIN, 32'hcccd);
      wb(1'b1, `AIOS_REG_OUT_MAX, 32'h1333);
      wb(1'b1, `AIOS_REG_OUT_CFG, 32'h11);
      pf_case(1'b0, 1'b0, 16'h1333, `AIOS_CODE_FULL);
      pf_case(1'b1, 1'b1, 16'h1333, `AIOS_CODE_FULL);
      pf_case(1'b0, 1'b1, 16'h3333, `AIOS_CODE_4MA);
      pf_case(1'b1, 1'b0, 16'h1333, `AIOS_CODE_4MA);
      $display("test power factor done");
      wb(1'b1, `AIOS_REG_IN_CFG, 32'h0);
      wb(1'b1, `AIOS_REG_THR_CFG, 32'h04170107);
      for (int e = 0; e < 4; e++) begin
         wb(1'b1, `AIOS_REG_THR_DLY, (32'(e) << 16) | 32'h6);
         wb(1'b1, `AIOS_REG_THR_LVL, (32'(e) << 16) | ((e == 0 || e == 3) ? 32'h3000 : 32'h5000));
      end
      code0 <= 16'h8000;
      repeat (3) @(posedge i_clk);
      code0 <= 16'h0000;
      repeat (3) @(posedge i_clk);
      code0 <= 16'h8000;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (trip[0] !== 1'b1 && n < 30);
      compares++;
      if (n < 7 || n > 12) begin
         n_errors++;
         $display("ERROR trip_delay expected %0d seen %0d", 8, n);
      end
      code1 <= 16'hc000;
      repeat (12) @(posedge i_clk);
      chk("alarm", 32'h7, {28'h0, alarm});
      chk("trip", 32'h5, {28'h0, trip});
      rd_chk("thr_state", `AIOS_REG_THR_STATE, 32'h57);
      rd_chk("in_val", `AIOS_REG_IN_VAL, 32'h6000_4000);
      rd_chk("status", `AIOS_REG_STATUS, 32'h15c);
      chk("irq", 32'h0, {31'h0, irq});
      wb(1'b1, `AIOS_REG_MASK, 32'h100);
      settle;
      chk("irq", 32'h1, {31'h0, irq});
      wb(1'b1, `AIOS_REG_STATUS, 32'h100);
      settle;
      chk("irq", 32'h0, {31'h0, irq});
      rd_chk("status", `AIOS_REG_STATUS, 32'h05c);
      $display("test thresholds done");
      wb(1'b1, `AIOS_REG_MASK, 32'h3);
      wb(1'b1, `AIOS_REG_IN_CFG, 32'h1);
      code0 <= 16'h2000;
      settle;
      chk("wire_broken", 32'h0, {30'h0, wire_broken});
      chk("alarm", 32'h6, {28'h0, alarm});
      open0 <= 1'b1;
      settle;
      chk("wire_broken", 32'h1, {30'h0, wire_broken});
      chk("alarm", 32'h4, {28'h0, alarm});
      chk("trip", 32'h4, {28'h0, trip});
      rd_chk("thr_state", `AIOS_REG_THR_STATE, 32'h144);
      chk("irq", 32'h1, {31'h0, irq});
      open0 <= 1'b0;
      settle;
      chk("wire_broken", 32'h0, {30'h0, wire_broken});
      $display("test broken wire done");
      results();
   end
endmodule : aios_top_test
